// ===== gyro_trim_cfg.svh
`ifndef GYRO_TRIM_CFG_SVH
`define GYRO_TRIM_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_NVM_CTRL      8'h33
`define IDX_CORR_MID      8'h36
`define IDX_CORR_X_HIGH   8'h37
`define IDX_CORR_Y_HIGH   8'h38
`define IDX_CORR_Z_HIGH   8'h39
`define IDX_SPARE_LOW     8'h3A
`define IDX_SPARE_BYTE    8'h3B
`define IDX_SELF_TEST     8'h3C
`define IDX_IRQ_STATUS    8'h40
`define IDX_IRQ_MASK      8'h41
`define IDX_SOFT_RESET    8'h42

// Self-test register fields.
`define ST_LAUNCH_BIT     0
`define ST_DONE_BIT       1
`define ST_FAIL_BIT       2
`define ST_HEALTH_BIT     4

// Non-volatile memory control fields.
`define NVM_MODE_BIT      0
`define NVM_TRIG_BIT      1
`define NVM_RDY_BIT       2
`define NVM_LOAD_BIT      3

// Interrupt status and mask fields.
`define IRQ_W             3
`define IRQ_BIST_DONE     0
`define IRQ_NVM_DONE      1
`define IRQ_LOAD_DONE     2

// Image layout and reset values.
`define NVM_BYTES         6
`define NVM_IDX_W         3
`define NVM_LAST_SLOT     3'h5
`define NVM_BLANK         8'h00
`define NVM_REMAIN_RESET  4'hF
`define CORR_RESET        12'h000
`define CORR_SHIFT        4

// Timing.
`define CLK_MHZ           200
`define CNT_W             16
`define BIST_TIME_US      2
`define BIST_CYCLES       (`BIST_TIME_US * `CLK_MHZ)
`define NVM_PROG_TIME_US  100

`endif

// ===== gyro_trim_pkg.sv
`include "gyro_trim_cfg.svh"

package gyro_trim_pkg;

  typedef enum logic [1:0] {NVM_IDLE, NVM_LOAD, NVM_PROG} nvm_state_e;
  typedef enum logic {BIST_IDLE, BIST_RUN} bist_state_e;

  // Index 0 is x, 1 is y, 2 is z.
  typedef struct packed {
    logic [2:0][15:0] axis;
  } rate_set_s;

  typedef struct packed {
    logic [2:0][11:0] axis;
  } corr_set_s;

  typedef struct packed {
    rate_set_s filt;
    rate_set_s unfilt;
  } rate_pair_s;

  typedef struct packed {
    corr_set_s                           corr;
    logic [3:0]                          spare_nibble;
    logic [7:0]                          spare_byte;
    bist_state_e                         bist;
    logic                                launch;
    logic                                done;
    logic                                fail;
    logic                                health;
    logic [`CNT_W-1:0]                   bist_cnt;
    nvm_state_e                          nvm;
    logic [`NVM_IDX_W-1:0]               load_idx;
    logic [`CNT_W-1:0]                   nvm_cnt;
    logic                                prog_mode;
    logic [3:0]                          remain;
    logic [`NVM_BYTES-1:0][7:0]          image;
    logic [`IRQ_W-1:0]                   irq_status;
    logic [`IRQ_W-1:0]                   irq_mask;
    logic                                ack;
    logic [7:0]                          rdata;
  } trim_state_s;

endpackage

// ===== rate_corr_sub.sv
`timescale 1ns/1ps

module rate_corr_sub (
  input  wire logic                    clk_i,    // System clock.
  input  wire logic                    rst_i,    // Synchronous reset, active high.
  input  wire gyro_trim_pkg::corr_set_s corr_i,  // Assembled 12-bit corrections.
  input  wire gyro_trim_pkg::rate_pair_s rate_i, // Raw filtered and unfiltered rates.
  output gyro_trim_pkg::rate_pair_s      rate_o  // Corrected rates.
);
  import gyro_trim_pkg::*;

  rate_pair_s       st;
  rate_pair_s       next_st;
  logic [2:0][15:0] diff_f;
  logic [2:0][15:0] diff_u;

  // The correction step is sixteen rate LSBs, so 2047 moves a zero reading
  // to about -124.94 deg/s and -2048 to +125 deg/s; results saturate rather
  // than wrap so an overflowing result never flips the sign of a reading.
  function automatic logic [15:0] sat_sub(input logic [15:0] r, input logic [11:0] c);
    logic signed [17:0] d;
    d = $signed({{2{r[15]}}, r}) - $signed({{2{c[11]}}, c, 4'h0});
    if (d > 18'sh07FFF)
      sat_sub = 16'h7FFF;
    else if (d < -18'sh08000)
      sat_sub = 16'h8000;
    else
      sat_sub = d[15:0];
  endfunction

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_axis
      assign diff_f[g] = sat_sub(rate_i.filt.axis[g], corr_i.axis[g]);
      assign diff_u[g] = sat_sub(rate_i.unfilt.axis[g], corr_i.axis[g]);
    end
  endgenerate

  always_comb
  begin
    next_st             = st;
    next_st.filt.axis   = diff_f;
    next_st.unfilt.axis = diff_u;
    if (rst_i)
      next_st = '0;
  end

  always_ff @(posedge clk_i)
  begin
    st <= next_st;
  end

  assign rate_o = st;

endmodule

// ===== gyro_trim_regs.sv
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps

module gyro_trim_regs #(
  parameter int NVM_PROG_CYCLES = `NVM_PROG_TIME_US * `CLK_MHZ  // Image write time in clocks.
) (
  input  wire logic                      clk_i,         // System clock, 200 MHz.
  input  wire logic                      rst_i,         // Synchronous power-on reset, active high.
  input  wire logic                      cyc_i,         // Wishbone cycle.
  input  wire logic                      stb_i,         // Wishbone strobe.
  input  wire logic                      we_i,          // Wishbone write enable.
  input  wire logic [3:0]                sel_i,         // Wishbone byte selects.
  input  wire logic [9:0]                adr_i,         // Wishbone byte address.
  input  wire logic [31:0]               dat_i,         // Wishbone write data.
  output logic      [31:0]               dat_o,         // Wishbone read data.
  output logic                           ack_o,         // Wishbone acknowledge.
  output logic                           irq_o,         // Level interrupt, active high.
  input  wire logic                      sensor_ok_i,   // Sensor health from the rate core.
  input  wire logic                      bist_pass_i,   // Self-test values in expected range.
  output logic                           bist_active_o, // Self-test stimulus enable.
  input  wire gyro_trim_pkg::rate_pair_s rate_i,        // Raw rates from the filters.
  output gyro_trim_pkg::rate_pair_s      rate_o         // Corrected rates.
);
  import gyro_trim_pkg::*;

  localparam int BIST_WAIT = `BIST_CYCLES;

  trim_state_s       st;
  trim_state_s       next_st;
  logic              req;
  logic              wr;
  logic [7:0]        idx;
  logic [`IRQ_W-1:0] ev;

  ////////////////////////////////////////////////////////////////////////////
  // Image byte mapping, shared by bus access, load and programming.

  function automatic logic is_image(input logic [7:0] i);
    is_image = (i >= `IDX_CORR_MID) && (i <= `IDX_SPARE_BYTE);
  endfunction

  function automatic logic [`NVM_IDX_W-1:0] image_slot(input logic [7:0] i);
    logic [7:0] d;
    d = i - `IDX_CORR_MID;
    image_slot = d[`NVM_IDX_W-1:0];
  endfunction

  function automatic logic [7:0] image_byte(input trim_state_s s, input logic [`NVM_IDX_W-1:0] k);
    case (k)
      3'h0:    image_byte = {s.corr.axis[0][3:2], s.corr.axis[1][3:1], s.corr.axis[2][3:1]};
      3'h1:    image_byte = s.corr.axis[0][11:4];
      3'h2:    image_byte = s.corr.axis[1][11:4];
      3'h3:    image_byte = s.corr.axis[2][11:4];
      3'h4:    image_byte = {s.spare_nibble, s.corr.axis[0][1:0], s.corr.axis[1][0], s.corr.axis[2][0]};
      3'h5:    image_byte = s.spare_byte;
      default: image_byte = 8'h00;
    endcase
  endfunction

  function automatic trim_state_s put_byte(input trim_state_s s, input logic [`NVM_IDX_W-1:0] k,
                                           input logic [7:0] b);
    put_byte = s;
    case (k)
      3'h0:
      begin
        put_byte.corr.axis[0][3:2] = b[7:6];
        put_byte.corr.axis[1][3:1] = b[5:3];
        put_byte.corr.axis[2][3:1] = b[2:0];
      end
      3'h1:    put_byte.corr.axis[0][11:4] = b;
      3'h2:    put_byte.corr.axis[1][11:4] = b;
      3'h3:    put_byte.corr.axis[2][11:4] = b;
      3'h4:
      begin
        put_byte.spare_nibble      = b[7:4];
        put_byte.corr.axis[0][1:0] = b[3:2];
        put_byte.corr.axis[1][0]   = b[1];
        put_byte.corr.axis[2][0]   = b[0];
      end
      3'h5:    put_byte.spare_byte = b;
      default: put_byte = s;
    endcase
  endfunction

  // Every reset starts an image load; rst_i also blanks the image, so after it
  // the corrections load as zero, and a soft reset or a write of the NVM load bit restores kept values.
  function automatic trim_state_s reset_state();
    reset_state          = '0;
    reset_state.corr     = '{axis: '{`CORR_RESET, `CORR_RESET, `CORR_RESET}};
    reset_state.bist     = BIST_IDLE;
    reset_state.nvm      = NVM_LOAD;
    reset_state.remain   = `NVM_REMAIN_RESET;
    reset_state.image    = {`NVM_BYTES{`NVM_BLANK}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  assign idx = adr_i[9:2];
  // No bus access is answered while the image loads, so half-restored
  // registers are never visible.
  assign req = cyc_i && stb_i && !st.ack && (st.nvm != NVM_LOAD);
  assign wr  = req && we_i && sel_i[0];

  always_comb
  begin
    next_st        = st;
    ev             = '0;
    next_st.ack    = 1'b0;
    next_st.health = sensor_ok_i;

    // Self-test sequencer.
    case (st.bist)
      BIST_IDLE:
      begin
        if (wr && (idx == `IDX_SELF_TEST) && dat_i[`ST_LAUNCH_BIT])
        begin
          next_st.bist     = BIST_RUN;
          next_st.launch   = 1'b1;
          next_st.done     = 1'b0;
          next_st.fail     = 1'b0;
          next_st.bist_cnt = `CNT_W'(`BIST_CYCLES - 1);
        end
      end
      BIST_RUN:
      begin
        if (st.bist_cnt == '0)
        begin
          next_st.bist  = BIST_IDLE;
          next_st.launch = 1'b0;
          next_st.done  = 1'b1;
          next_st.fail  = !bist_pass_i;
          ev[`IRQ_BIST_DONE] = 1'b1;
        end
        else
          next_st.bist_cnt = st.bist_cnt - `CNT_W'(1);
      end
      default: next_st.bist = BIST_IDLE;
    endcase

    // Image load and programming controller.
    case (st.nvm)
      NVM_IDLE:
      begin
        if (wr && (idx == `IDX_NVM_CTRL))
        begin
          next_st.prog_mode = dat_i[`NVM_MODE_BIT];
          // The unlock must already stand before the trigger write.
          if (dat_i[`NVM_TRIG_BIT] && st.prog_mode && (st.remain != 4'h0))
          begin
            next_st.nvm     = NVM_PROG;
            next_st.remain  = st.remain - 4'h1;
            next_st.nvm_cnt = `CNT_W'(NVM_PROG_CYCLES - 1);
            for (int k = 0; k < `NVM_BYTES; k++)
              next_st.image[k] = image_byte(st, `NVM_IDX_W'(k));
          end
          else if (dat_i[`NVM_LOAD_BIT])
          begin
            next_st.nvm      = NVM_LOAD;
            next_st.load_idx = '0;
          end
        end
      end
      NVM_LOAD:
      begin
        next_st = put_byte(next_st, st.load_idx, st.image[st.load_idx]);
        if (st.load_idx == `NVM_LAST_SLOT)
        begin
          next_st.nvm        = NVM_IDLE;
          ev[`IRQ_LOAD_DONE] = 1'b1;
        end
        else
          next_st.load_idx = st.load_idx + `NVM_IDX_W'(1);
      end
      NVM_PROG:
      begin
        if (st.nvm_cnt == '0)
        begin
          next_st.nvm       = NVM_IDLE;
          ev[`IRQ_NVM_DONE] = 1'b1;
        end
        else
          next_st.nvm_cnt = st.nvm_cnt - `CNT_W'(1);
      end
      default: next_st.nvm = NVM_IDLE;
    endcase

    // Direct register writes take effect without any image cycle.
    if (wr && is_image(idx))
      next_st = put_byte(next_st, image_slot(idx), dat_i[7:0]);
    if (wr && (idx == `IDX_IRQ_MASK))
      next_st.irq_mask = dat_i[`IRQ_W-1:0];

    // A new event in the clearing cycle stays set.
    if (wr && (idx == `IDX_IRQ_STATUS))
      next_st.irq_status = (st.irq_status & ~dat_i[`IRQ_W-1:0]) | ev;
    else
      next_st.irq_status = st.irq_status | ev;

    // Read data is captured with the request, so it shows pre-write values.
    next_st.rdata = 8'h00;
    if (req && !we_i)
    begin
      if (is_image(idx))
        next_st.rdata = image_byte(st, image_slot(idx));
      else
      begin
        case (idx)
          `IDX_SELF_TEST:
          begin
            next_st.rdata[`ST_HEALTH_BIT] = st.health;
            next_st.rdata[`ST_FAIL_BIT]   = st.fail;
            next_st.rdata[`ST_DONE_BIT]   = st.done;
            next_st.rdata[`ST_LAUNCH_BIT] = st.launch;
          end
          `IDX_NVM_CTRL:
          begin
            next_st.rdata[7:4]            = st.remain;
            next_st.rdata[`NVM_LOAD_BIT]  = 1'b0;
            next_st.rdata[`NVM_RDY_BIT]   = (st.nvm == NVM_IDLE);
            next_st.rdata[`NVM_MODE_BIT]  = st.prog_mode;
          end
          `IDX_IRQ_STATUS: next_st.rdata[`IRQ_W-1:0] = st.irq_status;
          `IDX_IRQ_MASK:   next_st.rdata[`IRQ_W-1:0] = st.irq_mask;
          default:         next_st.rdata = 8'h00;
        endcase
      end
    end
    next_st.ack = req;

    // Soft reset keeps the image and its write budget, then reloads.
    if (wr && (idx == `IDX_SOFT_RESET) && dat_i[0])
    begin
      next_st        = reset_state();
      next_st.image  = st.image;
      next_st.remain = st.remain;
      next_st.ack    = 1'b1;
    end

    if (rst_i)
      next_st = reset_state();
  end

  always_ff @(posedge clk_i)
  begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and the correction datapath.

  assign dat_o         = {24'h000000, st.rdata};
  assign ack_o         = st.ack;
  assign irq_o         = |(st.irq_status & st.irq_mask);
  assign bist_active_o = st.launch;

  rate_corr_sub u_corr (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .corr_i (st.corr),
    .rate_i (rate_i),
    .rate_o (rate_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_launch_clears;
    @(posedge clk_i) disable iff (rst_i)
    (st.bist == BIST_IDLE && wr && idx == `IDX_SELF_TEST && dat_i[0]) |=> (st.launch && !st.done && !st.fail);
  endproperty
  a_launch_clears: assert property (p_launch_clears) else $error("launch did not clear done and fail");

  property p_done_after_run;
    @(posedge clk_i) disable iff (rst_i)
    $rose(st.launch) |-> ##[BIST_WAIT:BIST_WAIT] ($rose(st.done) && !st.launch);
  endproperty
  a_done_after_run: assert property (p_done_after_run) else $error("self-test done at wrong time");

  property p_fail_result;
    @(posedge clk_i) disable iff (rst_i)
    $rose(st.done) |-> (st.fail == !$past(bist_pass_i));
  endproperty
  a_fail_result: assert property (p_fail_result) else $error("self-test fail flag wrong");

  property p_health_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !we_i && idx == `IDX_SELF_TEST) |=> (dat_o[`ST_HEALTH_BIT] == $past(sensor_ok_i, 2));
  endproperty
  a_health_read: assert property (p_health_read) else $error("health flag does not follow sensor");

  property p_prog_accept;
    @(posedge clk_i) disable iff (rst_i)
    (st.nvm == NVM_IDLE && wr && idx == `IDX_NVM_CTRL && dat_i[1] && st.prog_mode && st.remain != 4'h0)
      |=> (st.nvm == NVM_PROG && st.remain == $past(st.remain) - 4'h1);
  endproperty
  a_prog_accept: assert property (p_prog_accept) else $error("image write not taken or count wrong");

  property p_prog_refuse;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == `IDX_NVM_CTRL && dat_i[1] && (!st.prog_mode || st.remain == 4'h0 || st.nvm != NVM_IDLE))
      |=> (st.remain == $past(st.remain));
  endproperty
  a_prog_refuse: assert property (p_prog_refuse) else $error("refused image write changed count");

  property p_reload;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (st.nvm == NVM_LOAD && !ack_o) ##6 (st.nvm == NVM_IDLE);
  endproperty
  a_reload: assert property (p_reload) else $error("image not reloaded after reset");

  property p_write_direct;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == `IDX_CORR_X_HIGH) |=> (st.corr.axis[0][11:4] == $past(dat_i[7:0]) && ack_o);
  endproperty
  a_write_direct: assert property (p_write_direct) else $error("x correction write not direct");

endmodule

// ===== tb_gyro_trim_regs.sv
`timescale 1ns/1ps
`include "gyro_trim_cfg.svh"
`define TB_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_gyro_trim_regs;
  import gyro_trim_pkg::*;

  localparam int PROG_CYC = 20;

  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [3:0]  sel_i;
  logic [9:0]  adr_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        irq_o;
  logic        sensor_ok_i;
  logic        bist_pass_i;
  logic        bist_active_o;
  rate_pair_s  rate_i;
  rate_pair_s  rate_o;
  int          error_cnt;
  int          cmp_count;
  int          wait_cnt;
  integer      seed;
  logic [31:0] exp_q[$];
  logic [7:0]  img[6];
  logic [31:0] exp_word;

  gyro_trim_regs #(
    .NVM_PROG_CYCLES(PROG_CYC)
  ) u_dut (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .cyc_i         (cyc_i),
    .stb_i         (stb_i),
    .we_i          (we_i),
    .sel_i         (sel_i),
    .adr_i         (adr_i),
    .dat_i         (dat_i),
    .dat_o         (dat_o),
    .ack_o         (ack_o),
    .irq_o         (irq_o),
    .sensor_ok_i   (sensor_ok_i),
    .bist_pass_i   (bist_pass_i),
    .bist_active_o (bist_active_o),
    .rate_i        (rate_i),
    .rate_o        (rate_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Read data is judged at the ack edge, before the master releases the request.
  always @(posedge clk_i)
  begin
    if (ack_o === 1'b1 && we_i === 1'b0)
    begin
      exp_word = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hFFFF_FFFF;
      `TB_CHK(dat_o, exp_word)
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wb_cycle(input logic wr, input logic [7:0] idx, input logic [7:0] data);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, data};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wb_write(input logic [7:0] idx, input logic [7:0] data);
    wb_cycle(1'b1, idx, data);
  endtask

  task automatic wb_read(input logic [7:0] idx, input logic [7:0] exp);
    exp_q.push_back({24'h000000, exp});
    wb_cycle(1'b0, idx, 8'h00);
  endtask

  task automatic write_all;
    for (int i = 0; i < 6; i++)
      wb_write(8'h36 + 8'(i), img[i]);
  endtask

  task automatic read_all;
    for (int i = 0; i < 6; i++)
      wb_read(8'h36 + 8'(i), img[i]);
  endtask

  // Fills the trim bytes with fresh values, or writes their complement so a reload can be told apart.
  task automatic scramble(input logic keep);
    for (int i = 0; i < 6; i++)
    begin
      if (!keep)
        img[i] = 8'($random(seed));
      wb_write(8'h36 + 8'(i), keep ? ~img[i] : img[i]);
    end
  endtask

  task automatic wait_irq(input logic lvl);
    wait_cnt = 0;
    while (irq_o !== lvl && wait_cnt < 1000)
    begin
      @(posedge clk_i);
      wait_cnt++;
    end
    `TB_CHK(irq_o, lvl)
  endtask

  function automatic logic [11:0] corr_of(input int a);
    case (a)
      0:       return {img[1], img[0][7:6], img[4][3:2]};
      1:       return {img[2], img[0][5:3], img[4][1]};
      default: return {img[3], img[0][2:0], img[4][0]};
    endcase
  endfunction

  // The subtraction saturates, so the extreme codes must clamp rather than wrap.
  function automatic logic [15:0] corrected(input logic [15:0] r, input logic [11:0] c);
    int d;
    d = int'($signed(r)) - int'($signed(c)) * 16;
    if (d > 32767)
      d = 32767;
    if (d < -32768)
      d = -32768;
    return d[15:0];
  endfunction

  task automatic check_rate(input logic rnd);
    for (int a = 0; a < 3; a++)
    begin
      rate_i.filt.axis[a]   <= rnd ? 16'($random(seed)) : 16'h0000;
      rate_i.unfilt.axis[a] <= rnd ? 16'($random(seed)) : 16'h0000;
    end
    repeat (3) @(posedge clk_i);
    for (int a = 0; a < 3; a++)
    begin
      `TB_CHK(rate_o.filt.axis[a], corrected(rate_i.filt.axis[a], corr_of(a)))
      `TB_CHK(rate_o.unfilt.axis[a], corrected(rate_i.unfilt.axis[a], corr_of(a)))
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    seed        = 32'hc3099cab;
    error_cnt   = 0;
    cmp_count   = 0;
    rst_i       = 1'b1;
    cyc_i       = 1'b0;
    stb_i       = 1'b0;
    we_i        = 1'b0;
    sel_i       = 4'h1;
    adr_i       = 10'h000;
    dat_i       = 32'h0000_0000;
    sensor_ok_i = 1'b1;
    bist_pass_i = 1'b1;
    rate_i      = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++)
      img[i] = 8'h00;
    read_all;
    wb_read(`IDX_SELF_TEST, 8'h10);
    wb_read(`IDX_NVM_CTRL, 8'hF4);
    wb_read(`IDX_IRQ_MASK, 8'h00);
    // The power-on image load leaves its event pending; clear it so later level checks see only new events.
    wb_read(`IDX_IRQ_STATUS, 8'h04);
    wb_write(`IDX_IRQ_STATUS, 8'h04);
    wb_read(`IDX_IRQ_STATUS, 8'h00);
    wb_write(8'h35, 8'hA5);
    wb_read(8'h35, 8'h00);
    scramble(1'b0);
    read_all;
    check_rate(1'b1);
    img[0] = 8'hC0;
    img[1] = 8'h7F;
    img[2] = 8'h80;
    img[3] = 8'h00;
    img[4] = {img[4][7:4], 4'hC};
    write_all;
    check_rate(1'b0);
    `TB_CHK(rate_o.filt.axis[0], 16'h8010)
    `TB_CHK(rate_o.unfilt.axis[1], 16'h7FFF)
    `TB_CHK(rate_o.filt.axis[2], 16'h0000)
    // Second pass runs masked first, proving the mask gates the level output.
    for (int k = 0; k < 2; k++)
    begin
      bist_pass_i <= (k == 0);
      wb_write(`IDX_IRQ_MASK, (k == 0) ? 8'h07 : 8'h06);
      wb_write(`IDX_SELF_TEST, 8'h01);
      wb_read(`IDX_SELF_TEST, 8'h11);
      `TB_CHK(bist_active_o, 1'b1)
      repeat (420) @(posedge clk_i);
      `TB_CHK(irq_o, (k == 0))
      wb_write(`IDX_IRQ_MASK, 8'h07);
      wait_irq(1'b1);
      wb_read(`IDX_SELF_TEST, (k == 0) ? 8'h12 : 8'h16);
      wb_read(`IDX_IRQ_STATUS, 8'h01);
      wb_write(`IDX_IRQ_STATUS, 8'h01);
      wait_irq(1'b0);
    end
    sensor_ok_i <= 1'b0;
    wb_read(`IDX_SELF_TEST, 8'h06);
    sensor_ok_i <= 1'b1;
    scramble(1'b0);
    wb_write(`IDX_NVM_CTRL, 8'h01);
    wb_write(`IDX_NVM_CTRL, 8'h03);
    wait_irq(1'b1);
    wb_read(`IDX_NVM_CTRL, 8'hE5);
    scramble(1'b1);
    wb_write(`IDX_SOFT_RESET, 8'h01);
    read_all;
    wb_read(`IDX_IRQ_STATUS, 8'h04);
    wb_read(`IDX_NVM_CTRL, 8'hE4);
    wb_write(`IDX_NVM_CTRL, 8'h02);
    wb_read(`IDX_NVM_CTRL, 8'hE4);
    scramble(1'b1);
    wb_write(`IDX_NVM_CTRL, 8'h08);
    read_all;
    check_rate(1'b1);
    finish_test();
  end

endmodule
